//--- logic/tsc_regbank.sv
/*
  configuration and limit register bank of a temperature sensor, with
  end-of-conversion limit comparison and conversion scheduling.
  assumes command parsing outside: it gives pointer, direction, start and
  bit enables; the conversion engine gives result and done pulse.
*/
`timescale 1ns/10ps
module tsc_regbank #(
  parameter int CLK_HZ = tsc_pkg::CLK_HZ_DFLT
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_sys_rst,
  input  wire logic                       i_acc_start,
  input  wire logic                       i_acc_write,
  input  wire logic [1:0]                 i_acc_ptr,
  input  wire logic                       i_bit_en,
  input  wire logic                       i_bit_in,
  input  wire logic                       i_conv_done,
  input  wire logic [tsc_pkg::WORD_W-1:0] i_conv_result,
  output logic                            o_bit_out,
  output logic                            o_busy,
  output logic                            o_acc_done,
  output logic                            o_irq_enable,
  output logic [1:0]                      o_rate_select,
  output logic [1:0]                      o_mode,
  output logic                            o_ext_range,
  output logic                            o_high_hit,
  output logic                            o_low_hit,
  output logic                            o_conv_start
);
  import tsc_pkg::*;

  logic                irq_en;
  logic [1:0]          rate;
  logic                latch_sel;
  logic [1:0]          mode;
  logic                ext;
  logic                high_hit;
  logic                low_hit;
  logic [WORD_W-1:0]   low_lim;
  logic [WORD_W-1:0]   high_lim;
  logic                acc_wr_q;
  logic [1:0]          acc_ptr_q;
  logic                busy;
  logic                sd_done;
  logic [WORD_W-1:0]   sd_word;
  logic                acc_go;
  logic                rd_clear;
  logic                commit;
  logic [WORD_W-1:0]   cfg_word;
  logic [WORD_W-1:0]   rd_word;
  logic                hit_hi;
  logic                hit_lo;
  logic [PERIOD_W-1:0] per_cnt;
  logic                conv_start;

  // signed compare at the active resolution
  function automatic logic sgt(input logic [WORD_W-1:0] a,
                               input logic [WORD_W-1:0] b,
                               input logic              x);
    if (x) begin
      sgt = $signed(a[15:3]) > $signed(b[15:3]);
    end else begin
      sgt = $signed(a[15:4]) > $signed(b[15:4]);
    end
  endfunction

  function automatic logic [PERIOD_W-1:0] period(input logic [1:0] r);
    unique case (r)
      2'h0: period = PERIOD_W'(CLK_HZ / MS_PER_S * RATE_0_MS - 1);
      2'h1: period = PERIOD_W'(CLK_HZ / MS_PER_S * RATE_1_MS - 1);
      2'h2: period = PERIOD_W'(CLK_HZ / MS_PER_S * RATE_2_MS - 1);
      2'h3: period = PERIOD_W'(CLK_HZ / MS_PER_S * RATE_3_MS - 1);
    endcase
  endfunction

  // reserved bits 6:0 read as zero
  assign cfg_word = {irq_en, rate, high_hit, low_hit, latch_sel, mode, ext,
                     7'h00};

  // pointer decode; limits and result keep bits 2:0 at zero
  always_comb begin
    unique case (i_acc_ptr)
      PTR_TEMP: rd_word = i_conv_result & LIM_MASK;
      PTR_CFG:  rd_word = cfg_word;
      PTR_LOW:  rd_word = low_lim & LIM_MASK;
      PTR_HIGH: rd_word = high_lim & LIM_MASK;
    endcase
  end

  // a start while a transfer runs is ignored
  assign acc_go   = i_acc_start && !busy;
  assign rd_clear = acc_go && !i_acc_write && (i_acc_ptr == PTR_CFG) &&
                    !latch_sel;
  assign commit   = sd_done && acc_wr_q;
  assign hit_hi   = i_conv_done && sgt(i_conv_result, high_lim, ext);
  assign hit_lo   = i_conv_done && sgt(low_lim, i_conv_result, ext);

  tsc_serdes u_serdes (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_start     (acc_go),
    .i_load_word (rd_word),
    .i_bit_en    (i_bit_en),
    .i_bit_in    (i_bit_in),
    .o_bit_out   (o_bit_out),
    .o_busy      (busy),
    .o_done      (sd_done),
    .o_word      (sd_word)
  );

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      acc_wr_q  <= 1'b0;
      acc_ptr_q <= PTR_TEMP;
    end else if (acc_go) begin
      acc_wr_q  <= i_acc_write;
      acc_ptr_q <= i_acc_ptr;
    end
  end

  // configuration fields; flags are not writable
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      irq_en    <= CFG_RESET[CFG_IRQ_BIT];
      rate      <= CFG_RESET[CFG_RATE_HI:CFG_RATE_LO];
      latch_sel <= CFG_RESET[CFG_LATCH_BIT];
      mode      <= CFG_RESET[CFG_MODE_HI:CFG_MODE_LO];
      ext       <= CFG_RESET[CFG_EXT_BIT];
    end else if (commit && acc_ptr_q == PTR_CFG) begin
      irq_en    <= sd_word[CFG_IRQ_BIT];
      rate      <= sd_word[CFG_RATE_HI:CFG_RATE_LO];
      latch_sel <= sd_word[CFG_LATCH_BIT];
      mode      <= sd_word[CFG_MODE_HI:CFG_MODE_LO];
      ext       <= sd_word[CFG_EXT_BIT];
    end
  end

  // set wins over read-clear so a hit in the clear cycle survives
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      high_hit <= CFG_RESET[CFG_HHIT_BIT];
      low_hit  <= CFG_RESET[CFG_LHIT_BIT];
    end else begin
      high_hit <= hit_hi || (high_hit && !rd_clear);
      low_hit  <= hit_lo || (low_hit && !rd_clear);
    end
  end

  // tag bit kept in normal range; writes to pointer 00 drop silently
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      low_lim  <= LOW_RESET;
      high_lim <= HIGH_RESET;
    end else if (commit) begin
      if (acc_ptr_q == PTR_LOW) begin
        low_lim <= sd_word & LIM_MASK;
        if (!ext) begin
          low_lim[LIM_TAG_BIT] <= low_lim[LIM_TAG_BIT];
        end
      end
      if (acc_ptr_q == PTR_HIGH) begin
        high_lim <= sd_word & LIM_MASK;
        if (!ext) begin
          high_lim[LIM_TAG_BIT] <= high_lim[LIM_TAG_BIT];
        end
      end
    end
  end

  // continuous pacing; a rate change takes effect at once via >=
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      per_cnt <= '0;
    end else if (!mode[1] || per_cnt >= period(rate)) begin
      per_cnt <= '0;
    end else begin
      per_cnt <= per_cnt + PERIOD_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= (mode[1] && per_cnt >= period(rate)) ||
                    (commit && acc_ptr_q == PTR_CFG &&
                     sd_word[CFG_MODE_HI:CFG_MODE_LO] == MODE_ONESHOT);
    end
  end

  assign o_busy        = busy;
  assign o_acc_done    = sd_done;
  assign o_irq_enable  = irq_en;
  assign o_rate_select = rate;
  assign o_mode        = mode;
  assign o_ext_range   = ext;
  assign o_high_hit    = high_hit;
  assign o_low_hit     = low_hit;
  assign o_conv_start  = conv_start;

  sequence s_cfg_read;
    acc_go && !i_acc_write && i_acc_ptr == PTR_CFG;
  endsequence

  sequence s_low_commit_norm;
    commit && acc_ptr_q == PTR_LOW && !ext;
  endsequence

  // checked at each release, so a reset in mid-run is covered as well
  a_cfg_reset: assert property (@(posedge i_clk)
    $fell(i_sys_rst) |-> cfg_word == CFG_RESET && low_lim == LOW_RESET &&
                         high_lim == HIGH_RESET)
    else $error("registers not at reset value");

  a_first_bit: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    acc_go |=> o_bit_out == $past(rd_word[0]) && busy)
    else $error("first bit out is not the lsb");

  a_done_pulse: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    sd_done |-> !busy ##1 !sd_done)
    else $error("transfer done is not a single idle-cycle pulse");

  a_rsvd_zero: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    acc_go |-> (rd_word & ~CFG_MASK) == 16'h0000 ||
               i_acc_ptr != PTR_CFG)
    else $error("reserved configuration bits not zero");

  a_high_set: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    hit_hi |=> high_hit [*2] or (high_hit ##1 $fell(high_hit)))
    else $error("high flag not set after crossing");

  a_high_ext: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    i_conv_done && ext &&
    $signed(i_conv_result[15:3]) > $signed(high_lim[15:3]) |=> high_hit)
    else $error("high flag not set after extended crossing");

  a_low_set: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    i_conv_done && $signed(i_conv_result[15:4]) < $signed(low_lim[15:4])
    && !ext |=> low_hit)
    else $error("low flag not set after crossing");

  a_low_ext: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    i_conv_done && ext &&
    $signed(i_conv_result[15:3]) < $signed(low_lim[15:3]) |=> low_hit)
    else $error("low flag not set after extended crossing");

  a_read_clear: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    s_cfg_read ##0 (!latch_sel && !i_conv_done) |=> !high_hit && !low_hit)
    else $error("flags not cleared by read");

  a_latch_hold: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    latch_sel && high_hit && !commit |=> high_hit)
    else $error("latched high flag lost");

  a_tag_keep: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    s_low_commit_norm |=> low_lim[LIM_TAG_BIT] ==
                          $past(low_lim[LIM_TAG_BIT]))
    else $error("tag bit written in normal range");

  a_oneshot: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    commit && acc_ptr_q == PTR_CFG &&
    sd_word[CFG_MODE_HI:CFG_MODE_LO] == MODE_ONESHOT
    |=> conv_start ##1 !conv_start)
    else $error("one-shot start missing or repeated");

  // a one-shot commit may legally follow a paced start back to back
  a_start_pulse: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    conv_start && !commit |=> !conv_start)
    else $error("conversion start longer than one cycle");

  a_shutdown: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    mode == MODE_SHUTDOWN && $past(mode) == MODE_SHUTDOWN |-> !conv_start)
    else $error("conversion started in shutdown");

  a_lim_rsvd: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    acc_go && i_acc_ptr[1] |-> rd_word[2:0] == 3'h0)
    else $error("limit bits 2:0 not zero");

endmodule // tsc_regbank

//--- logic/tsc_pkg.sv
/*
  shared constants for the temperature sensor configuration and limit bank:
  register pointers, field positions, reset values, conversion timing.
  assumes nothing beyond a SystemVerilog-2012 compiler.
*/
package tsc_pkg;

  localparam int WORD_W   = 16;
  localparam int PERIOD_W = 28;

  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG  = 2'h1;
  localparam logic [1:0] PTR_LOW  = 2'h2;
  localparam logic [1:0] PTR_HIGH = 2'h3;

  localparam int CFG_IRQ_BIT   = 15;
  localparam int CFG_RATE_HI   = 14;
  localparam int CFG_RATE_LO   = 13;
  localparam int CFG_HHIT_BIT  = 12;
  localparam int CFG_LHIT_BIT  = 11;
  localparam int CFG_LATCH_BIT = 10;
  localparam int CFG_MODE_HI   = 9;
  localparam int CFG_MODE_LO   = 8;
  localparam int CFG_EXT_BIT   = 7;
  localparam int LIM_TAG_BIT   = 3;

  localparam logic [15:0] CFG_RESET  = 16'h0200;
  localparam logic [15:0] LOW_RESET  = 16'hf600;
  localparam logic [15:0] HIGH_RESET = 16'h3c00;
  localparam logic [15:0] LIM_MASK   = 16'hfff8;
  localparam logic [15:0] CFG_MASK   = 16'hff80;

  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] MODE_ONESHOT  = 2'h1;

  localparam int MS_PER_S     = 1000;
  localparam int RATE_0_MS    = 4000;
  localparam int RATE_1_MS    = 1000;
  localparam int RATE_2_MS    = 250;
  localparam int RATE_3_MS    = 125;
  localparam int CLK_HZ_DFLT  = 25000000;

  typedef enum logic [1:0] {
    TSC_IDLE  = 2'b01,
    TSC_SHIFT = 2'b10
  } tsc_state_t;

endpackage

//--- logic/tsc_serdes.sv
/*
  16-bit serial shifter for register transfers, least significant bit first.
  assumes one bit per i_bit_en pulse and a start only while not busy.
*/
`timescale 1ns/10ps
module tsc_serdes (
  input  wire logic                       i_clk,
  input  wire logic                       i_sys_rst,
  input  wire logic                       i_start,
  input  wire logic [tsc_pkg::WORD_W-1:0] i_load_word,
  input  wire logic                       i_bit_en,
  input  wire logic                       i_bit_in,
  output logic                            o_bit_out,
  output logic                            o_busy,
  output logic                            o_done,
  output logic [tsc_pkg::WORD_W-1:0]      o_word
);
  import tsc_pkg::*;

  localparam int CW = $clog2(WORD_W);
  localparam logic [CW-1:0] LAST = CW'(WORD_W - 1);

  tsc_state_t        state;
  logic [WORD_W-1:0] sh;
  logic [CW-1:0]     cnt;
  logic              done;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= TSC_IDLE;
      sh    <= '0;
      cnt   <= '0;
    end else begin
      unique case (state)
        TSC_IDLE: begin
          if (i_start) begin
            sh    <= i_load_word;
            cnt   <= '0;
            state <= TSC_SHIFT;
          end
        end
        TSC_SHIFT: begin
          // lsb leaves first, new bits enter at the top
          if (i_bit_en) begin
            sh  <= {i_bit_in, sh[WORD_W-1:1]};
            cnt <= cnt + CW'(1);
            if (cnt == LAST) begin
              state <= TSC_IDLE;
            end
          end
        end
        default: state <= TSC_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      done <= 1'b0;
    end else begin
      done <= (state == TSC_SHIFT) && i_bit_en && (cnt == LAST);
    end
  end

  assign o_bit_out = sh[0];
  assign o_busy    = (state == TSC_SHIFT);
  assign o_done    = done;
  assign o_word    = sh;

endmodule // tsc_serdes

//--- tb/tsc_host_model.sv
/*
  host side of the register link: one 16-bit transfer per xfer call, with
  random stalls between bit slots. assumes tsc_regbank at the far side.
*/
`timescale 1ns/10ps
module tsc_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_bit_out,
  input  wire logic       i_acc_done,
  output logic            o_acc_start,
  output logic            o_acc_write,
  output logic [1:0]      o_acc_ptr,
  output logic            o_bit_en,
  output logic            o_bit_in
);
  initial begin
    o_acc_start = 1'b0;
    o_acc_write = 1'b0;
    o_acc_ptr   = 2'h0;
    o_bit_en    = 1'b0;
    o_bit_in    = 1'b0;
  end

  // pointer and direction held for the whole transfer
  task automatic xfer(input logic w, input logic [1:0] p,
                      input logic [15:0] d, output logic [15:0] r,
                      output bit ok);
    int k;
    int n;
    int s;
    ok = 1'b0;
    @(posedge i_clk);
    o_acc_start <= 1'b1;
    o_acc_write <= w;
    o_acc_ptr   <= p;
    @(posedge i_clk);
    o_acc_start <= 1'b0;
    for (k = 0; k < 16; k++) begin
      o_bit_en <= 1'b1;
      o_bit_in <= d[k]; // bit0 first
      @(posedge i_clk);
      r[k] = i_bit_out; // bit0 first
      // slow host: up to two idle cycles, none after the last slot so
      // the one-cycle done pulse is not missed
      s = 0;
      if (k < 15)
        s = $urandom_range(2);
      if (s > 0 || k == 15) begin
        o_bit_en <= 1'b0;
        // released line must not keep the last value
        o_bit_in <= ~d[k];
        repeat (s) @(posedge i_clk);
      end
    end
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge i_clk);
      ok = (i_acc_done === 1'b1);
    end
  endtask
endmodule // tsc_host_model

//--- tb/temp_sensor_config_limits_tb_top.sv
/*
  self-checking bench for tsc_regbank: integer model of the register bank
  and flags, compared after every transfer and conversion.
  assumes tsc_host_model drives the link side.
*/
`timescale 1ns/10ps
module temp_sensor_config_limits_tb_top;
  import tsc_pkg::*;
  logic              i_clk = 1'b0;
  logic              i_sys_rst = 1'b1;
  logic              conv_done = 1'b0;
  logic [WORD_W-1:0] conv_res = '0;
  logic              acc_start, acc_write, bit_en, bit_in, bit_out;
  logic              busy, acc_done, irq_en, ext, hh, lh, conv_start;
  logic [1:0]        acc_ptr, rate, mode;
  logic [15:0]       m_cfg, m_low, m_high, rd, d, st;
  logic              m_hh, m_lh;
  bit                ok;
  int                errors = 0;
  int                num_checks = 0;

  always #20 i_clk = ~i_clk;

  // short rate periods keep continuous mode cheap
  tsc_regbank #(.CLK_HZ(8000)) DUT (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_acc_start(acc_start),
    .i_acc_write(acc_write), .i_acc_ptr(acc_ptr), .i_bit_en(bit_en),
    .i_bit_in(bit_in), .i_conv_done(conv_done),
    .i_conv_result(conv_res), .o_bit_out(bit_out), .o_busy(busy),
    .o_acc_done(acc_done), .o_irq_enable(irq_en), .o_rate_select(rate),
    .o_mode(mode), .o_ext_range(ext), .o_high_hit(hh), .o_low_hit(lh),
    .o_conv_start(conv_start));

  tsc_host_model host (
    .i_clk(i_clk), .i_bit_out(bit_out), .i_acc_done(acc_done),
    .o_acc_start(acc_start), .o_acc_write(acc_write), .o_acc_ptr(acc_ptr),
    .o_bit_en(bit_en), .o_bit_in(bit_in));

  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // tag bit kept when normal range is active
  function automatic logic [15:0] lim(input logic [15:0] v, old);
    return m_cfg[7] ? (v & 16'hfff8) : ((v & 16'hfff0) | (old & 16'h0008));
  endfunction

  task automatic outs(input bit os = 1'b0);
    @(posedge i_clk);
    chk({7'h0, busy, irq_en, rate, mode, ext, hh, lh},
        {7'h0, 1'b0, m_cfg[15:13], m_cfg[9:7], m_hh, m_lh});
    if (os)
      chk({15'h0, conv_start}, 16'h0001);
  endtask

  task automatic acc(input logic w, input logic [1:0] p,
                     input logic [15:0] v);
    logic [15:0] exp;
    host.xfer(w, p, v, rd, ok);
    chk(16'(ok), 16'h0001);
    if (!ok)
      end_sim();
    if (w) begin
      case (p)
        PTR_CFG:  m_cfg = v & 16'he780;
        PTR_LOW:  m_low = lim(v, m_low);
        PTR_HIGH: m_high = lim(v, m_high);
        default: ;
      endcase
      outs(w && p == PTR_CFG && v[9:8] == MODE_ONESHOT);
    end else begin
      case (p)
        PTR_TEMP: exp = conv_res & 16'hfff8;
        PTR_CFG:  exp = m_cfg | {3'h0, m_hh, m_lh, 11'h0};
        PTR_LOW:  exp = m_low;
        default:  exp = m_high;
      endcase
      chk(rd, exp);
      if (p == PTR_CFG && !m_cfg[10])
        {m_hh, m_lh} = 2'b00;
    end
  endtask

  task automatic conv(input logic [15:0] r);
    @(posedge i_clk);
    conv_res  <= r;
    conv_done <= 1'b1;
    @(posedge i_clk);
    conv_done <= 1'b0;
    if (m_cfg[7] ? $signed(r[15:3]) > $signed(m_high[15:3])
                 : $signed(r[15:4]) > $signed(m_high[15:4]))
      m_hh = 1'b1;
    if (m_cfg[7] ? $signed(r[15:3]) < $signed(m_low[15:3])
                 : $signed(r[15:4]) < $signed(m_low[15:4]))
      m_lh = 1'b1;
    outs();
  endtask

  initial begin
    void'($urandom(32'h48f1));
    m_cfg  = CFG_RESET;
    m_low  = LOW_RESET;
    m_high = HIGH_RESET;
    m_hh   = 1'b0;
    m_lh   = 1'b0;
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    outs();
    acc(1'b0, PTR_CFG, 16'h0);
    acc(1'b0, PTR_LOW, 16'h0);
    acc(1'b0, PTR_HIGH, 16'h0);
    acc(1'b1, PTR_CFG, 16'hffff);
    acc(1'b0, PTR_CFG, 16'h0);
    acc(1'b1, PTR_TEMP, 16'h1234);
    acc(1'b0, PTR_TEMP, 16'h0);
    for (int i = 0; i < 12; i++) begin
      d = 16'($urandom);
      d[7] = i[0];
      d[10] = i[1];
      // shutdown, one-shot and continuous each get four rounds
      d[9:8] = i[3:2];
      acc(1'b1, PTR_CFG, d);
      // both limits rewritten after a range change
      acc(1'b1, PTR_LOW, 16'($urandom) | 16'h8000);
      acc(1'b1, PTR_HIGH, 16'($urandom) & 16'h7fff);
      acc(1'b0, PTR_LOW, 16'h0);
      acc(1'b0, PTR_HIGH, 16'h0);
      st = m_cfg[7] ? 16'h0008 : 16'h0010;
      conv(m_high);
      conv(m_low);
      acc(1'b0, PTR_CFG, 16'h0);
      conv(m_high + st);
      conv(m_low - st);
      conv(16'($urandom));
      acc(1'b0, PTR_CFG, 16'h0);
      acc(1'b0, PTR_CFG, 16'h0);
      acc(1'b0, PTR_TEMP, 16'h0);
    end
    // reset in mid-run must bring every register back to its default
    i_sys_rst <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    m_cfg  = CFG_RESET;
    m_low  = LOW_RESET;
    m_high = HIGH_RESET;
    m_hh   = 1'b0;
    m_lh   = 1'b0;
    outs();
    acc(1'b0, PTR_CFG, 16'h0);
    acc(1'b0, PTR_LOW, 16'h0);
    acc(1'b0, PTR_HIGH, 16'h0);
    end_sim();
  end
endmodule // temp_sensor_config_limits_tb_top
